// ==== pmss_fifo.sv ====
package pmss_pkg;
    // APB register map, byte addresses
    localparam int PMSS_AW = 8;
    localparam logic [7:0] PMSS_OFF_CTRL = 8'h00;
    localparam logic [7:0] PMSS_OFF_STATE = 8'h04;
    localparam logic [7:0] PMSS_OFF_TXCTRL = 8'h08;
    localparam logic [7:0] PMSS_OFF_TXDATA = 8'h0c;
    localparam logic [7:0] PMSS_OFF_STATUS = 8'h10;
    localparam logic [7:0] PMSS_OFF_TIMING = 8'h14;
    // Mode control fields
    localparam int PMSS_CTRL_MOD = 0;
    localparam int PMSS_CTRL_HI = 1;
    localparam int PMSS_CTRL_SPR = 2;
    localparam int PMSS_CTRL_ALT = 4;
    localparam int PMSS_CTRL_SACK = 5;
    localparam int PMSS_CTRL_SCR = 6;
    localparam int PMSS_CTRL_EXT = 7;
    localparam logic [7:0] PMSS_CTRL_RST = 8'h40;
    localparam int PMSS_TXCTRL_HDR = 4;
    localparam logic [1:0] PMSS_SPR_STD = 2'h0;
    localparam logic [1:0] PMSS_SPR_X2 = 2'h1;
    localparam logic [1:0] PMSS_SPR_X4 = 2'h2;
    // Reference clock in kHz, 125 MHz
    localparam logic [16:0] PMSS_CLK_KHZ = 17'h1e848;
    localparam int PMSS_CLK_MHZ = 125;
    // Chip rates in kchip/s
    localparam logic [9:0] PMSS_CR_300 = 10'h12c;
    localparam logic [9:0] PMSS_CR_600 = 10'h258;
    localparam logic [9:0] PMSS_CR_400 = 10'h190;
    localparam logic [9:0] PMSS_CR_1000 = 10'h3e8;
    // Payload rates in kb/s
    localparam logic [10:0] PMSS_DR_20 = 11'h014;
    localparam logic [10:0] PMSS_DR_40 = 11'h028;
    localparam logic [10:0] PMSS_DR_100 = 11'h064;
    localparam logic [10:0] PMSS_DR_200 = 11'h0c8;
    localparam logic [10:0] PMSS_DR_400 = 11'h190;
    localparam logic [10:0] PMSS_DR_250 = 11'h0fa;
    localparam logic [10:0] PMSS_DR_500 = 11'h1f4;
    localparam logic [10:0] PMSS_DR_1000 = 11'h3e8;
    // Chips per data bit
    localparam logic [3:0] PMSS_CPB_BPSK = 4'hf;
    localparam logic [3:0] PMSS_CPB_STD = 4'h4;
    localparam logic [3:0] PMSS_CPB_X2 = 4'h2;
    localparam logic [3:0] PMSS_CPB_X4 = 4'h1;
    // Symbol periods in microseconds and cycles
    localparam logic [5:0] PMSS_SYM_US_50 = 6'h32;
    localparam logic [5:0] PMSS_SYM_US_25 = 6'h19;
    localparam logic [5:0] PMSS_SYM_US_40 = 6'h28;
    localparam logic [5:0] PMSS_SYM_US_16 = 6'h10;
    localparam int PMSS_SYM50_CYC = int'(PMSS_SYM_US_50) * PMSS_CLK_MHZ;
    localparam int PMSS_SYM25_CYC = int'(PMSS_SYM_US_25) * PMSS_CLK_MHZ;
    localparam int PMSS_SYM40_CYC = int'(PMSS_SYM_US_40) * PMSS_CLK_MHZ;
    localparam int PMSS_SYM16_CYC = int'(PMSS_SYM_US_16) * PMSS_CLK_MHZ;
    // Acknowledge time in symbol periods
    localparam logic [3:0] PMSS_ACK_STD = 4'hc;
    localparam logic [3:0] PMSS_ACK_LO = 4'h2;
    localparam logic [3:0] PMSS_ACK_HI = 4'h3;
    // Spreading pattern and scrambler seed, arbitrary values
    localparam logic [15:0] PMSS_PN = 16'h3a5c;
    localparam logic [6:0] PMSS_SCR_SEED = 7'h7f;
    localparam int PMSS_FIFO_W = 8;
    localparam int PMSS_FIFO_D = 16;

    typedef enum logic [2:0] {
        PMSS_SH_RC10 = 3'b000,
        PMSS_SH_SIN_RC02 = 3'b001,
        PMSS_SH_RC02 = 3'b010,
        PMSS_SH_SIN = 3'b011,
        PMSS_SH_RC08 = 3'b100
    } pmss_shape_e;

    typedef enum logic [1:0] {
        PMSS_ST_IDLE = 2'b00,
        PMSS_ST_FETCH = 2'b01,
        PMSS_ST_WAITD = 2'b10,
        PMSS_ST_SEND = 2'b11
    } pmss_state_e;
endpackage : pmss_pkg

`timescale 1ns/100ps
`default_nettype none
module pmss_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [W-1:0] wr_data,
    // Drain side, data registered one cycle after the pop
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [W-1:0] rd_data,
    output logic [$clog2(D):0] count
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic [W-1:0] rd_data_ff, nxt_rd_data;
    logic push, pop;

    always_comb begin
        push = wr_valid && (cnt_ff != (AW+1)'(D));
        pop = rd_ready && (cnt_ff != '0);
        nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
        nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
        nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        nxt_rd_data = pop ? mem[rp_ff] : rd_data_ff;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
            rd_data_ff <= '0;
        end else begin
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            cnt_ff <= nxt_cnt;
            rd_data_ff <= nxt_rd_data;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_ff] <= wr_data;
        end
    end

    assign wr_ready = (cnt_ff != (AW+1)'(D));
    assign rd_valid = (cnt_ff != '0);
    assign rd_data = rd_data_ff;
    assign count = cnt_ff;
endmodule : pmss_fifo
`default_nettype wire

// ==== pmss_mode_codec.sv ====
`timescale 1ns/100ps
`default_nettype none
module pmss_mode_codec #(
    parameter int unsigned SYM50_CYC = pmss_pkg::PMSS_SYM50_CYC,
    parameter int unsigned SYM25_CYC = pmss_pkg::PMSS_SYM25_CYC,
    parameter int unsigned SYM40_CYC = pmss_pkg::PMSS_SYM40_CYC,
    parameter int unsigned SYM16_CYC = pmss_pkg::PMSS_SYM16_CYC
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pmss_pkg::PMSS_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Chip stream to the modulator
    output logic chip_strobe,
    output logic chip_data,
    output logic [2:0] pulse_shape,
    output logic payload_active,
    output logic symbol_tick
);
    import pmss_pkg::*;

    logic [7:0] cfg_ff, nxt_cfg;
    logic trx_on_ff, nxt_trx_on;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic mod, hi, alt, sack, scen;
    logic [1:0] spr;
    logic [9:0] chip_k;
    logic [10:0] pay_kb;
    logic [3:0] base_cpb, pay_cpb, cur_cpb, ack_sym;
    logic [2:0] shape;
    logic [5:0] sym_us;
    logic [12:0] sym_cyc;
    logic scr_act;
    logic is_ctrl, is_state, is_txctrl, is_txdata, is_status, is_timing, mapped;
    logic access, done, start, push;
    logic fifo_wr_ready, fifo_rd_valid, fifo_rd_ready;
    logic [7:0] fifo_rd_data;
    logic [4:0] fifo_count;
    pmss_state_e st_ff, nxt_st;

    // Mode decode; the extended-mode bit does not alter rates
    always_comb begin
        mod = cfg_ff[PMSS_CTRL_MOD];
        hi = cfg_ff[PMSS_CTRL_HI];
        spr = cfg_ff[PMSS_CTRL_SPR +: 2];
        alt = cfg_ff[PMSS_CTRL_ALT];
        sack = cfg_ff[PMSS_CTRL_SACK];
        scen = cfg_ff[PMSS_CTRL_SCR];
        if (!mod) begin
            chip_k = hi ? PMSS_CR_600 : PMSS_CR_300;
            base_cpb = PMSS_CPB_BPSK;
            pay_cpb = PMSS_CPB_BPSK;
            pay_kb = hi ? PMSS_DR_40 : PMSS_DR_20;
            shape = PMSS_SH_RC10;
            sym_us = hi ? PMSS_SYM_US_25 : PMSS_SYM_US_50;
            sym_cyc = hi ? 13'(SYM25_CYC) : 13'(SYM50_CYC);
        end else begin
            // Chip rate set by hi alone, spreading choice cannot move it
            chip_k = hi ? PMSS_CR_1000 : PMSS_CR_400;
            base_cpb = PMSS_CPB_STD;
            case (spr)
                PMSS_SPR_X2: pay_cpb = PMSS_CPB_X2;
                PMSS_SPR_X4: pay_cpb = PMSS_CPB_X4;
                default: pay_cpb = PMSS_CPB_STD;
            endcase
            case (spr)
                PMSS_SPR_X2: pay_kb = hi ? PMSS_DR_500 : PMSS_DR_200;
                PMSS_SPR_X4: pay_kb = hi ? PMSS_DR_1000 : PMSS_DR_400;
                default: pay_kb = hi ? PMSS_DR_250 : PMSS_DR_100;
            endcase
            if (hi) begin
                shape = alt ? PMSS_SH_RC08 : PMSS_SH_SIN;
            end else begin
                shape = alt ? PMSS_SH_RC02 : PMSS_SH_SIN_RC02;
            end
            sym_us = hi ? PMSS_SYM_US_16 : PMSS_SYM_US_40;
            sym_cyc = hi ? 13'(SYM16_CYC) : 13'(SYM40_CYC);
        end
        if (sack && mod && (spr == PMSS_SPR_X2 || spr == PMSS_SPR_X4)) begin
            ack_sym = hi ? PMSS_ACK_HI : PMSS_ACK_LO;
        end else begin
            ack_sym = PMSS_ACK_STD;
        end
        scr_act = mod && (spr == PMSS_SPR_X4) && scen;
    end

    // APB slave: one wait state, so the read mux and full check are registered
    always_comb begin
        is_ctrl = (paddr == PMSS_OFF_CTRL);
        is_state = (paddr == PMSS_OFF_STATE);
        is_txctrl = (paddr == PMSS_OFF_TXCTRL);
        is_txdata = (paddr == PMSS_OFF_TXDATA);
        is_status = (paddr == PMSS_OFF_STATUS);
        is_timing = (paddr == PMSS_OFF_TIMING);
        mapped = is_ctrl | is_state | is_txctrl | is_txdata | is_status | is_timing;
        access = psel && penable;
        done = access && pready_ff;
        // Full FIFO holds the bus off rather than dropping the byte
        nxt_pready = access && !pready_ff && !(pwrite && is_txdata && !fifo_wr_ready);
        nxt_pslverr = nxt_pready && (!mapped || (pwrite && is_ctrl && trx_on_ff));
        nxt_prdata = '0;
        if (nxt_pready && !pwrite) begin
            if (is_ctrl) nxt_prdata = {24'h0, cfg_ff};
            if (is_state) nxt_prdata = {30'h0, (st_ff != PMSS_ST_IDLE), trx_on_ff};
            if (is_txdata) nxt_prdata = {27'h0, fifo_count};
            if (is_status) nxt_prdata = {4'h0, ack_sym, shape, pay_kb, chip_k};
            if (is_timing) nxt_prdata = {26'h0, sym_us};
        end
        nxt_cfg = cfg_ff;
        if (done && pwrite && is_ctrl && !trx_on_ff) begin
            nxt_cfg = pwdata[7:0];
        end
        nxt_trx_on = (done && pwrite && is_state) ? pwdata[0] : trx_on_ff;
        push = done && pwrite && is_txdata;
        start = done && pwrite && is_txctrl && pwdata[0] && trx_on_ff && (st_ff == PMSS_ST_IDLE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_ff <= PMSS_CTRL_RST;
            trx_on_ff <= 1'b0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else begin
            cfg_ff <= nxt_cfg;
            trx_on_ff <= nxt_trx_on;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    pmss_fifo #(.W(PMSS_FIFO_W), .D(PMSS_FIFO_D)) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .wr_valid(push),
        .wr_ready(fifo_wr_ready),
        .wr_data(pwdata[7:0]),
        .rd_valid(fifo_rd_valid),
        .rd_ready(fifo_rd_ready),
        .rd_data(fifo_rd_data),
        .count(fifo_count)
    );

    // Chip sequencer
    logic [16:0] acc_ff, nxt_acc, acc_sum;
    logic tick;
    logic [7:0] byte_ff, nxt_byte;
    logic [2:0] bit_ff, nxt_bit;
    logic [3:0] chip_ff, nxt_chip, hdr_ff, nxt_hdr;
    logic [6:0] lfsr_ff, nxt_lfsr;
    logic pay_ff, nxt_pay, cs_ff, nxt_cs, cd_ff, nxt_cd, raw;
    logic [2:0] shape_ff;

    always_comb begin
        // Phase accumulator in kHz: remainder carries over, so no drift
        acc_sum = acc_ff + {7'h0, chip_k};
        tick = trx_on_ff && (acc_sum >= PMSS_CLK_KHZ);
        nxt_acc = !trx_on_ff ? '0 : (tick ? acc_sum - PMSS_CLK_KHZ : acc_sum);
        cur_cpb = pay_ff ? pay_cpb : base_cpb;
        raw = byte_ff[bit_ff] ^ PMSS_PN[chip_ff];
        nxt_st = st_ff;
        nxt_byte = byte_ff;
        nxt_bit = bit_ff;
        nxt_chip = chip_ff;
        nxt_hdr = hdr_ff;
        nxt_lfsr = lfsr_ff;
        nxt_pay = pay_ff;
        nxt_cs = 1'b0;
        nxt_cd = cd_ff;
        fifo_rd_ready = 1'b0;
        case (st_ff)
            PMSS_ST_IDLE: begin
                if (start) begin
                    nxt_hdr = pwdata[PMSS_TXCTRL_HDR +: 4];
                    nxt_lfsr = PMSS_SCR_SEED;
                    nxt_pay = 1'b0;
                    nxt_st = PMSS_ST_FETCH;
                end
            end
            PMSS_ST_FETCH: begin
                // An empty FIFO at a byte boundary ends the frame
                fifo_rd_ready = fifo_rd_valid;
                nxt_st = fifo_rd_valid ? PMSS_ST_WAITD : PMSS_ST_IDLE;
            end
            PMSS_ST_WAITD: begin
                nxt_byte = fifo_rd_data;
                nxt_bit = '0;
                nxt_chip = '0;
                nxt_pay = (hdr_ff == '0);
                nxt_st = PMSS_ST_SEND;
            end
            PMSS_ST_SEND: begin
                if (tick) begin
                    nxt_cs = 1'b1;
                    if (pay_ff && scr_act) begin
                        nxt_cd = raw ^ lfsr_ff[0];
                        nxt_lfsr = {lfsr_ff[0] ^ lfsr_ff[1], lfsr_ff[6:1]};
                    end else begin
                        nxt_cd = raw;
                    end
                    if (chip_ff == cur_cpb - 4'h1) begin
                        nxt_chip = '0;
                        nxt_bit = bit_ff + 3'h1;
                        if (bit_ff == 3'h7) begin
                            nxt_hdr = (hdr_ff != '0) ? hdr_ff - 4'h1 : hdr_ff;
                            nxt_st = PMSS_ST_FETCH;
                        end
                    end else begin
                        nxt_chip = chip_ff + 4'h1;
                    end
                end
            end
            default: nxt_st = PMSS_ST_IDLE;
        endcase
        if (!trx_on_ff) begin
            nxt_st = PMSS_ST_IDLE;
            nxt_cs = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= PMSS_ST_IDLE;
            acc_ff <= '0;
            byte_ff <= '0;
            bit_ff <= '0;
            chip_ff <= '0;
            hdr_ff <= '0;
            lfsr_ff <= PMSS_SCR_SEED;
            pay_ff <= 1'b0;
            cs_ff <= 1'b0;
            cd_ff <= 1'b0;
            shape_ff <= PMSS_SH_RC10;
        end else begin
            st_ff <= nxt_st;
            acc_ff <= nxt_acc;
            byte_ff <= nxt_byte;
            bit_ff <= nxt_bit;
            chip_ff <= nxt_chip;
            hdr_ff <= nxt_hdr;
            lfsr_ff <= nxt_lfsr;
            pay_ff <= nxt_pay;
            cs_ff <= nxt_cs;
            cd_ff <= nxt_cd;
            shape_ff <= shape;
        end
    end

    // Symbol period timer; hi selects the shorter period in either modulation
    logic [12:0] sym_cnt_ff, nxt_sym_cnt;
    logic sym_tick_ff, nxt_sym_tick;

    always_comb begin
        nxt_sym_tick = trx_on_ff && (sym_cnt_ff == sym_cyc - 13'h1);
        if (!trx_on_ff || nxt_sym_tick) begin
            nxt_sym_cnt = '0;
        end else begin
            nxt_sym_cnt = sym_cnt_ff + 13'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sym_cnt_ff <= '0;
            sym_tick_ff <= 1'b0;
        end else begin
            sym_cnt_ff <= nxt_sym_cnt;
            sym_tick_ff <= nxt_sym_tick;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign chip_strobe = cs_ff;
    assign chip_data = cd_ff;
    assign pulse_shape = shape_ff;
    assign payload_active = pay_ff;
    assign symbol_tick = sym_tick_ff;

    // Helpers for the checks below
    logic [8:0] gap_ff, gap_lo;
    logic gap_seen_ff, raw_ff, sym_seen_ff;
    logic [12:0] sym_gap_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_ff <= '0;
            gap_seen_ff <= 1'b0;
            raw_ff <= 1'b0;
            sym_gap_ff <= '0;
            sym_seen_ff <= 1'b0;
        end else begin
            gap_ff <= tick ? 9'h1 : gap_ff + 9'h1;
            gap_seen_ff <= trx_on_ff && (gap_seen_ff || tick);
            raw_ff <= raw;
            sym_gap_ff <= sym_tick_ff ? 13'h1 : sym_gap_ff + 13'h1;
            sym_seen_ff <= trx_on_ff && (sym_seen_ff || sym_tick_ff);
        end
    end
    assign gap_lo = 9'(PMSS_CLK_KHZ / {7'h0, chip_k});

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    cfg_lock_a: assert property (trx_on_ff && $past(trx_on_ff) |-> $stable(cfg_ff))
        else $error("mode fields changed while transceiver on");
    chip_gap_a: assert property (tick && gap_seen_ff |-> gap_ff == gap_lo || gap_ff == gap_lo + 9'h1)
        else $error("chip spacing off the selected chip rate");
    bpsk_mode_a: assert property (st_ff == PMSS_ST_SEND && !mod |-> cur_cpb == PMSS_CPB_BPSK && pulse_shape == PMSS_SH_RC10)
        else $error("bpsk spreading or shaping wrong");
    oqpsk_shape_a: assert property (trx_on_ff && $past(trx_on_ff) && mod |-> pulse_shape == (hi ? (alt ? PMSS_SH_RC08 : PMSS_SH_SIN) : (alt ? PMSS_SH_RC02 : PMSS_SH_SIN_RC02)))
        else $error("oqpsk pulse shape wrong");
    header_rate_a: assert property (st_ff == PMSS_ST_SEND && !pay_ff |->
        cur_cpb == (mod ? PMSS_CPB_STD : PMSS_CPB_BPSK))
        else $error("header not at base rate");
    high_rate_a: assert property (st_ff == PMSS_ST_SEND && pay_ff && mod && spr == PMSS_SPR_X4 |-> cur_cpb == PMSS_CPB_X4 && chip_k == (hi ? PMSS_CR_1000 : PMSS_CR_400))
        else $error("shortened code length or chip rate wrong");
    scram_off_a: assert property (chip_strobe && !($past(scr_act) && payload_active) |-> chip_data == raw_ff)
        else $error("chip scrambled when it should not be");
    sym_period_a: assert property (sym_tick_ff && sym_seen_ff && $past(trx_on_ff) |-> sym_gap_ff == sym_cyc)
        else $error("symbol period wrong");
    ack_time_a: assert property (!sack |-> ack_sym == PMSS_ACK_STD)
        else $error("default ack time not twelve symbols");
    apb_full_a: assert property (psel && penable && pwrite && is_txdata && !fifo_wr_ready |=> !pready)
        else $error("write accepted into full fifo");
endmodule : pmss_mode_codec
`default_nettype wire

// ==== pmss_rf_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module pmss_rf_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Chip stream from the codec
    input wire logic chip_strobe,
    input wire logic chip_data,
    input wire logic payload_active,
    input wire logic symbol_tick,
    input wire logic [2:0] pulse_shape,
    // Measurements toward the bench
    input wire logic clr,
    output var int n_chip,
    output var int n_pay,
    output var int gap_min,
    output var int gap_max,
    output var int tick_gap,
    output var logic [2:0] shape_seen,
    output var logic [31:0] chip_tail
);
    int since_chip = 0;
    int since_tick = 0;
    // Front-end only listens; the codec has no back-pressure from it
    always @(posedge pclk) begin
        since_chip++;
        since_tick++;
        if (clr || !presetn) begin
            n_chip = 0;
            n_pay = 0;
            gap_min = 32'h7fff;
            gap_max = 0;
            chip_tail = 32'h0;
        end else if (chip_strobe) begin
            // First chip of a frame has no gap before it
            if (n_chip > 0 && since_chip < gap_min) gap_min = since_chip;
            if (n_chip > 0 && since_chip > gap_max) gap_max = since_chip;
            since_chip = 0;
            chip_tail = {chip_tail[30:0], chip_data};
            n_chip++;
            if (payload_active) n_pay++;
            shape_seen = pulse_shape;
        end
        if (symbol_tick) begin
            tick_gap = since_tick;
            since_tick = 0;
        end
    end
endmodule : pmss_rf_model
`default_nettype wire

// ==== phy_mode_spreading_select_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin err_total++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module phy_mode_spreading_select_tb_top;
    import pmss_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clr = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, chip_strobe, chip_data, payload_active, symbol_tick;
    logic [2:0] pulse_shape, shape_seen;
    logic [31:0] chip_tail;
    int n_chip, n_pay, gap_min, gap_max, tick_gap, err_total = 0, cmp_count = 0, cyc = 0;

    always #4 pclk = ~pclk;

    // Short symbol counts keep the run brief
    pmss_mode_codec #(.SYM50_CYC(50), .SYM25_CYC(25), .SYM40_CYC(40), .SYM16_CYC(16)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chip_strobe(chip_strobe), .chip_data(chip_data), .pulse_shape(pulse_shape),
        .payload_active(payload_active), .symbol_tick(symbol_tick));
    pmss_rf_model m (.pclk(pclk), .presetn(presetn), .chip_strobe(chip_strobe),
        .chip_data(chip_data), .chip_tail(chip_tail),
        .payload_active(payload_active), .symbol_tick(symbol_tick), .pulse_shape(pulse_shape),
        .clr(clr), .n_chip(n_chip), .n_pay(n_pay), .gap_min(gap_min), .gap_max(gap_max),
        .tick_gap(tick_gap), .shape_seen(shape_seen));

    task final_report;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    function automatic logic [31:0] st(logic [9:0] kc, logic [10:0] kb, logic [2:0] sh,
                                       logic [3:0] ak);
        return {4'h0, ak, sh, kb, kc};
    endfunction : st

    // Chips of one unscrambled, standard-spread byte, LSB first, newest chip lowest
    function automatic logic [31:0] chips_std(logic [7:0] b);
        logic [31:0] r;
        r = 32'h0;
        for (int i = 0; i < 8; i++) begin
            for (int c = 0; c < int'(PMSS_CPB_STD); c++) r = {r[30:0], b[i] ^ PMSS_PN[c]};
        end
        return r;
    endfunction : chips_std

    task mode(input logic [7:0] c, input logic [31:0] s, input logic [5:0] us);
        apb(1'b1, PMSS_OFF_CTRL, {24'h0, c});
        apb(1'b0, PMSS_OFF_STATUS, 32'h0);
        `CHK("status", s, rd)
        apb(1'b0, PMSS_OFF_TIMING, 32'h0);
        `CHK("symbol period", {26'h0, us}, rd)
    endtask : mode

    task frame(input logic [7:0] c, input int nb, input int tot, input int pay, input int gmin,
               input int gmax, input int tk, input logic [2:0] sh);
        apb(1'b1, PMSS_OFF_STATE, 32'h0);
        apb(1'b1, PMSS_OFF_CTRL, {24'h0, c});
        apb(1'b1, PMSS_OFF_STATE, 32'h1);
        for (int i = 0; i < nb; i++) apb(1'b1, PMSS_OFF_TXDATA, 32'h5a + 32'(i));
        apb(1'b0, PMSS_OFF_TXDATA, 32'h0);
        `CHK("fifo count", 32'(nb), rd)
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        apb(1'b1, PMSS_OFF_TXCTRL, 32'h11);
        do apb(1'b0, PMSS_OFF_STATE, 32'h0); while (rd[1] !== 1'b0);
        `CHK("chips", tot, n_chip)
        `CHK("payload chips", pay, n_pay)
        `CHK("gap min", gmin, gap_min)
        `CHK("gap max", gmax, gap_max)
        `CHK("tick gap", tk, tick_gap)
        `CHK("shape", sh, shape_seen)
        apb(1'b0, PMSS_OFF_TXDATA, 32'h0);
        `CHK("fifo drained", 32'h0, rd)
    endtask : frame

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 80000) begin
            err_total++;
            final_report;
        end
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, PMSS_OFF_CTRL, 32'h0);
        `CHK("ctrl reset", 32'h40, rd)
        apb(1'b0, 8'h18, 32'h0);
        `CHK("unmapped error", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        mode(8'h40, st(PMSS_CR_300, PMSS_DR_20, PMSS_SH_RC10, PMSS_ACK_STD), 6'h32);
        mode(8'h42, st(PMSS_CR_600, PMSS_DR_40, PMSS_SH_RC10, PMSS_ACK_STD), 6'h19);
        mode(8'h41, st(PMSS_CR_400, PMSS_DR_100, PMSS_SH_SIN_RC02, PMSS_ACK_STD), 6'h28);
        mode(8'h75, st(PMSS_CR_400, PMSS_DR_200, PMSS_SH_RC02, PMSS_ACK_LO), 6'h28);
        mode(8'h69, st(PMSS_CR_400, PMSS_DR_400, PMSS_SH_SIN_RC02, PMSS_ACK_LO), 6'h28);
        mode(8'h43, st(PMSS_CR_1000, PMSS_DR_250, PMSS_SH_SIN, PMSS_ACK_STD), 6'h10);
        mode(8'h77, st(PMSS_CR_1000, PMSS_DR_500, PMSS_SH_RC08, PMSS_ACK_HI), 6'h10);
        mode(8'heb, st(PMSS_CR_1000, PMSS_DR_1000, PMSS_SH_SIN, PMSS_ACK_HI), 6'h10);
        apb(1'b1, PMSS_OFF_STATE, 32'h1);
        apb(1'b1, PMSS_OFF_CTRL, 32'h40);
        `CHK("ctrl write while on", 1'b1, err)
        apb(1'b0, PMSS_OFF_CTRL, 32'h0);
        `CHK("ctrl kept", 32'heb, rd)
        frame(8'heb, 16, 152, 120, 125, 125, 16, PMSS_SH_SIN);
        frame(8'h41, 2, 64, 32, 312, 313, 40, PMSS_SH_SIN_RC02);
        `CHK("payload chip data", chips_std(8'h5b), chip_tail)
        final_report;
    end
endmodule : phy_mode_spreading_select_tb_top
`default_nettype wire
